/* File: design/hbpci_defs.svh */
// Constants of the host bridge PCI side control block.
`ifndef HBPCI_DEFS_SVH
`define HBPCI_DEFS_SVH
`define HBPCI_NUM_MASTERS 4
`define HBPCI_CMD_MEM_READ 4'h6
`define HBPCI_CMD_MEM_WRITE 4'h7
`define HBPCI_CMD_MEM_READ_MULT 4'hc
`define HBPCI_CMD_MEM_READ_LINE 4'he
`define HBPCI_CMD_WRITE_BIT 0
`define HBPCI_SERR_PULSE_NS 5
`define HBPCI_CLK_PERIOD_NS 5
`define HBPCI_SERR_PULSE_CYCLES (`HBPCI_SERR_PULSE_NS / `HBPCI_CLK_PERIOD_NS)
`endif

/* File: design/hbpci_pkg.sv */
// Types of the host bridge PCI side control block.
package hbpci_pkg;
  typedef enum logic [3:0] {
    HBPCI_HOLD_IDLE = 4'h1,
    HBPCI_HOLD_FLUSH = 4'h2,
    HBPCI_HOLD_ACK = 4'h4,
    HBPCI_HOLD_REARM = 4'h8
  } hbpci_hold_state_type;
endpackage : hbpci_pkg

/* File: design/hbpci_parity.sv */
// Even parity over address/data and command/byte-enable lines.
`timescale 1ns/10ps
`default_nettype none
module hbpci_parity (
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  output logic par
);
  // XOR of all 36 lines makes the total count of ones, with parity, even.
  assign par = ^{ad, cbe_n};
endmodule : hbpci_parity
`default_nettype wire

/* File: design/hbpci_arbiter.sv */
// Round-robin arbiter for four external bus masters.
`timescale 1ns/10ps
`default_nettype none
`include "hbpci_defs.svh"
module hbpci_arbiter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] master_request_n,
  input wire logic block,
  output logic [3:0] master_grant_n
);
  logic [3:0] grant;
  logic [3:0] next_grant;
  logic [1:0] last;
  logic [1:0] pick;
  logic found;

  always_comb begin
    next_grant = 4'h0;
    pick = last;
    found = 1'b0;
    for (int i = 1; i <= `HBPCI_NUM_MASTERS; i++) begin
      if (!found && !master_request_n[2'(last + 2'(i))]) begin
        pick = 2'(last + 2'(i));
        found = 1'b1;
      end
    end
    if (!block) begin
      if (|(grant & ~master_request_n)) begin
        next_grant = grant;
      end else if (found) begin
        next_grant = 4'h1 << pick;
      end
    end
  end

  // One-hot grant, withdrawn while the south bridge holds the bus.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      grant <= 4'h0;
      last <= 2'h3;
    end else begin
      grant <= next_grant;
      if (next_grant != grant && found && next_grant != 4'h0) begin
        last <= pick;
      end
    end
  end

  assign master_grant_n = ~grant;

  a_grant_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot0(~master_grant_n)) else $error("More than one grant.");
  a_grant_blocked: assert property (@(posedge clk_sys) disable iff (rst)
    $past(block) |-> master_grant_n == 4'hf) else $error("Grant during hold.");
  a_grant_requested: assert property (@(posedge clk_sys) disable iff (rst)
    !master_grant_n[0] |-> !$past(master_request_n[0])) else $error("Unrequested grant.");
  c_grant_any: cover property (@(posedge clk_sys) master_grant_n != 4'hf);
endmodule : hbpci_arbiter
`default_nettype wire

/* File: design/hbpci_ctrl.sv */
// PCI side control: parity, target handshake, system error, hold and arbitration.
`timescale 1ns/10ps
`default_nettype none
`include "hbpci_defs.svh"
module hbpci_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic system_error_enable,
  input wire logic ecc_mode,
  input wire logic ecc_report_single,
  input wire logic ecc_report_multi,
  input wire logic ecc_single_err,
  input wire logic ecc_multi_err,
  input wire logic ecc_init_done,
  input wire logic report_pci_parity,
  input wire logic report_gfx_parity,
  input wire logic report_gtt_invalid,
  input wire logic report_gfx_range,
  input wire logic gfx_parity_err,
  input wire logic gtt_invalid_hit,
  input wire logic gfx_out_of_range,
  input wire logic gfx_target_abort,
  input wire logic init_active,
  input wire logic init_is_write,
  input wire logic init_addr_phase,
  input wire logic init_data_phase,
  input wire logic [31:0] init_ad,
  input wire logic [3:0] init_cbe_n,
  input wire logic cpu_lock_req,
  input wire logic tgt_ready,
  input wire logic tgt_disconnect,
  input wire logic tgt_retry,
  input wire logic tgt_abort,
  input wire logic [31:0] tgt_read_data,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic trdy_n_in,
  input wire logic stop_n_in,
  input wire logic devsel_n_in,
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_n_in,
  input wire logic par_in,
  input wire logic exclusive_lock_n_in,
  output logic par_out,
  output logic par_oe,
  output logic trdy_n_out,
  output logic trdy_oe,
  output logic stop_n_out,
  output logic stop_oe,
  output logic exclusive_lock_n_out,
  output logic exclusive_lock_oe,
  output logic serr_n_out,
  output logic serr_oe,
  output logic init_trdy_seen,
  output logic init_stop_seen,
  output logic init_target_abort,
  output logic tgt_selected,
  output logic [3:0] tgt_cmd,
  output logic [31:0] tgt_addr,
  output logic pci_lock_ignored,
  input wire logic posted_writes_empty,
  output logic posted_writes_enable,
  input wire logic south_bridge_hold_req_n,
  output logic south_bridge_hold_ack_n,
  input wire logic [3:0] master_request_n,
  output logic [3:0] master_grant_n
);
  hbpci_pkg::hbpci_hold_state_type hold_state;
  logic frame_prev;
  logic tgt_active;
  logic tgt_mem_read;
  logic par_drive_next;
  logic [35:0] par_src;
  logic par_calc;
  logic par_check_addr;
  logic par_check_data;
  logic [31:0] last_ad;
  logic [3:0] last_cbe_n;
  logic par_err;
  logic ecc_err;
  logic serr_event;
  logic [3:0] serr_cnt;
  logic lock_own;
  logic tgt_addr_phase;

  hbpci_parity u_parity (
    .ad(par_src[35:4]),
    .cbe_n(par_src[3:0]),
    .par(par_calc)
  );

  hbpci_arbiter u_arbiter (
    .clk_sys(clk_sys),
    .rst(rst),
    .master_request_n(master_request_n),
    .block(hold_state == hbpci_pkg::HBPCI_HOLD_FLUSH ||
      hold_state == hbpci_pkg::HBPCI_HOLD_ACK),
    .master_grant_n(master_grant_n)
  );

  // Target decode: address and command taken on the first FRAME# low edge.
  assign tgt_addr_phase = !frame_n_in && frame_prev && !init_active;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_prev <= 1'b1;
      tgt_active <= 1'b0;
      tgt_cmd <= 4'h0;
      tgt_addr <= 32'h0;
      tgt_mem_read <= 1'b0;
    end else begin
      frame_prev <= frame_n_in;
      if (tgt_addr_phase) begin
        tgt_cmd <= cbe_n_in;
        tgt_addr <= ad_in;
        tgt_active <= 1'b1;
        tgt_mem_read <= cbe_n_in == `HBPCI_CMD_MEM_READ ||
          cbe_n_in == `HBPCI_CMD_MEM_READ_MULT || cbe_n_in == `HBPCI_CMD_MEM_READ_LINE;
      end else if (tgt_active && frame_n_in && !irdy_n_in &&
                   (!trdy_n_out || !stop_n_out)) begin
        tgt_active <= 1'b0;
      end
    end
  end
  assign tgt_selected = tgt_active;

  // Target handshake outputs, driven only while targeted.
  assign trdy_oe = tgt_active;
  assign trdy_n_out = !(tgt_active && tgt_ready && !tgt_retry && !tgt_abort);
  assign stop_oe = tgt_active;
  assign stop_n_out = !(tgt_active && (tgt_disconnect || tgt_retry || tgt_abort));

  // Initiator samples the target's answer.
  assign init_trdy_seen = init_active && !trdy_n_in;
  assign init_stop_seen = init_active && !stop_n_in;
  assign init_target_abort = init_active && !stop_n_in && devsel_n_in;

  // Lock: only processor locks are driven; PCI-originated locks are flagged only.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_own <= 1'b0;
    end else begin
      lock_own <= cpu_lock_req && init_active;
    end
  end
  assign exclusive_lock_oe = lock_own;
  assign exclusive_lock_n_out = !lock_own;
  assign pci_lock_ignored = tgt_active && !exclusive_lock_n_in;

  // Parity source for the driven phase; PAR follows one clock after it.
  always_comb begin
    par_drive_next = 1'b0;
    par_src = {last_ad, last_cbe_n};
    if (init_active && (init_addr_phase || (init_data_phase && init_is_write))) begin
      par_drive_next = 1'b1;
      par_src = {init_ad, init_cbe_n};
    end else if (tgt_active && tgt_mem_read) begin
      par_drive_next = 1'b1;
      par_src = {tgt_read_data, cbe_n_in};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      par_out <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      par_out <= par_calc;
      par_oe <= par_drive_next;
    end
  end

  // Checking of parity received on the bus.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_ad <= 32'h0;
      last_cbe_n <= 4'h0;
      par_check_addr <= 1'b0;
      par_check_data <= 1'b0;
    end else begin
      last_ad <= ad_in;
      last_cbe_n <= cbe_n_in;
      par_check_addr <= tgt_addr_phase;
      par_check_data <= tgt_active && !tgt_mem_read && !irdy_n_in && !trdy_n_out;
    end
  end
  assign par_err = (par_check_addr || par_check_data) && (par_in != ^{last_ad, last_cbe_n});

  // System error sources, all gated by the global enable.
  assign ecc_err = ecc_mode && ecc_init_done &&
    ((ecc_single_err && ecc_report_single) || (ecc_multi_err && ecc_report_multi));
  assign serr_event = system_error_enable && (ecc_err ||
    init_target_abort ||
    gfx_target_abort ||
    (par_err && report_pci_parity) ||
    (gfx_parity_err && report_gfx_parity) ||
    (gtt_invalid_hit && report_gtt_invalid) ||
    (gfx_out_of_range && report_gfx_range));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serr_cnt <= 4'h0;
    end else if (!system_error_enable) begin
      serr_cnt <= 4'h0;
    end else if (serr_event) begin
      serr_cnt <= 4'(`HBPCI_SERR_PULSE_CYCLES);
    end else if (serr_cnt != 4'h0) begin
      serr_cnt <= serr_cnt - 4'h1;
    end
  end
  assign serr_oe = serr_cnt != 4'h0;
  assign serr_n_out = !serr_oe;

  // South bridge hold: flush, disable posted writes, acknowledge, release.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_state <= hbpci_pkg::HBPCI_HOLD_IDLE;
      posted_writes_enable <= 1'b1;
      south_bridge_hold_ack_n <= 1'b1;
    end else begin
      case (hold_state)
        hbpci_pkg::HBPCI_HOLD_IDLE: begin
          if (!south_bridge_hold_req_n) begin
            hold_state <= hbpci_pkg::HBPCI_HOLD_FLUSH;
          end
        end
        hbpci_pkg::HBPCI_HOLD_FLUSH: begin
          if (south_bridge_hold_req_n) begin
            hold_state <= hbpci_pkg::HBPCI_HOLD_IDLE;
          end else if (posted_writes_empty && master_grant_n == 4'hf) begin
            posted_writes_enable <= 1'b0;
            south_bridge_hold_ack_n <= 1'b0;
            hold_state <= hbpci_pkg::HBPCI_HOLD_ACK;
          end
        end
        hbpci_pkg::HBPCI_HOLD_ACK: begin
          if (south_bridge_hold_req_n) begin
            south_bridge_hold_ack_n <= 1'b1;
            hold_state <= hbpci_pkg::HBPCI_HOLD_REARM;
          end
        end
        hbpci_pkg::HBPCI_HOLD_REARM: begin
          posted_writes_enable <= 1'b1;
          hold_state <= hbpci_pkg::HBPCI_HOLD_IDLE;
        end
        default: begin
          hold_state <= hbpci_pkg::HBPCI_HOLD_IDLE;
        end
      endcase
    end
  end

  a_serr_enable: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(system_error_enable) |-> serr_n_out) else $error("SERR without enable.");
  a_serr_abort: assert property (@(posedge clk_sys) disable iff (rst)
    (system_error_enable && init_target_abort) |=> !serr_n_out) else $error("Abort unreported.");
  a_serr_gfx: assert property (@(posedge clk_sys) disable iff (rst)
    (system_error_enable && gfx_target_abort) |=> !serr_n_out) else $error("Gfx abort lost.");
  a_serr_one: assert property (@(posedge clk_sys) disable iff (rst)
    (!serr_n_out && !$past(serr_event)) |-> 1'b0) else $error("SERR too long.");
  a_ecc_serr: assert property (@(posedge clk_sys) disable iff (rst)
    (system_error_enable && ecc_err) |=> !serr_n_out) else $error("ECC unreported.");
  a_ack_flushed: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(south_bridge_hold_ack_n) |-> !posted_writes_enable && $past(posted_writes_empty))
    else $error("Ack before flush.");
  a_ack_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (!south_bridge_hold_ack_n && !south_bridge_hold_req_n) |=> !south_bridge_hold_ack_n)
    else $error("Ack dropped early.");
  a_hold_no_grant: assert property (@(posedge clk_sys) disable iff (rst)
    !south_bridge_hold_ack_n |-> master_grant_n == 4'hf) else $error("Grant during ack.");
  a_rearm_writes: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(south_bridge_hold_ack_n) |=> posted_writes_enable) else $error("Writes not rearmed.");
  a_par_read: assert property (@(posedge clk_sys) disable iff (rst)
    (init_active && init_data_phase && !init_is_write && !init_addr_phase && !tgt_active)
    |=> !par_oe) else $error("Parity on read data.");
  a_par_target: assert property (@(posedge clk_sys) disable iff (rst)
    (tgt_active && tgt_mem_read && !init_active) |=> par_oe) else $error("Target parity.");
  a_par_even: assert property (@(posedge clk_sys) disable iff (rst)
    $past(par_drive_next) |-> ^{$past(par_src), par_out} == 1'b0) else $error("Odd parity.");
  a_capture: assert property (@(posedge clk_sys) disable iff (rst)
    tgt_addr_phase |=> tgt_addr == $past(ad_in) && tgt_cmd == $past(cbe_n_in))
    else $error("Address not captured.");
  a_trdy_ready: assert property (@(posedge clk_sys) disable iff (rst)
    !trdy_n_out |-> tgt_active && tgt_ready) else $error("TRDY not ready.");
  a_lock_cpu: assert property (@(posedge clk_sys) disable iff (rst)
    exclusive_lock_oe |-> $past(cpu_lock_req)) else $error("Lock not from CPU.");
  c_hold_cycle: cover property (@(posedge clk_sys) $rose(south_bridge_hold_ack_n));
  c_serr_pulse: cover property (@(posedge clk_sys) !serr_n_out);
  c_target_read: cover property (@(posedge clk_sys) tgt_active && tgt_mem_read && par_oe);
  c_target_stop: cover property (@(posedge clk_sys) !stop_n_out);
endmodule : hbpci_ctrl
`default_nettype wire

/* File: verification/hbpci_far_side.sv */
// Far side model: south bridge hold requester and processor posted write buffer.
`timescale 1ns/10ps
`default_nettype none
module hbpci_far_side (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hold_start,
  input wire logic south_bridge_hold_ack_n,
  output logic south_bridge_hold_req_n,
  output logic posted_writes_empty
);
  logic [3:0] own;
  logic [3:0] pending;
  // The request stays low until the bus has been owned for four cycles.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      south_bridge_hold_req_n <= 1'b1;
      own <= 4'h0;
    end else if (hold_start) begin
      south_bridge_hold_req_n <= 1'b0;
    end else if (own == 4'h4) begin
      south_bridge_hold_req_n <= 1'b1;
      own <= 4'h0;
    end else if (!south_bridge_hold_ack_n && !south_bridge_hold_req_n) begin
      own <= own + 4'h1;
    end
  end
  // Posted writes drain only while a hold is pending; the processor refills them otherwise.
  always_ff @(posedge clk_sys) begin
    if (rst || south_bridge_hold_req_n) begin
      pending <= 4'h3;
    end else if (pending != 4'h0) begin
      pending <= pending - 4'h1;
    end
  end
  assign posted_writes_empty = (pending == 4'h0);
endmodule : hbpci_far_side
`default_nettype wire

/* File: verification/hbpci_ctrl_tb_top.sv */
// Testbench of the host bridge PCI side control block.
`timescale 1ns/10ps
`default_nettype none
module hbpci_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic system_error_enable = 1'b0, ecc_mode = 1'b1, ecc_report_single = 1'b1;
  logic ecc_report_multi = 1'b1, ecc_init_done = 1'b1, report_pci_parity = 1'b1;
  logic report_gfx_parity = 1'b1, report_gtt_invalid = 1'b1, report_gfx_range = 1'b1;
  logic init_active = 1'b0, init_is_write = 1'b0, init_addr_phase = 1'b0;
  logic init_data_phase = 1'b0, cpu_lock_req = 1'b0, tgt_ready = 1'b0;
  logic tgt_disconnect = 1'b0, tgt_retry = 1'b0, tgt_abort = 1'b0, hold_start = 1'b0;
  logic frame_n_in = 1'b1, irdy_n_in = 1'b1, trdy_n_in = 1'b1, devsel_n_in = 1'b1;
  logic par_in = 1'b0, exclusive_lock_n_in = 1'b1;
  logic [31:0] init_ad = 32'h0, tgt_read_data = 32'h0, ad_in = 32'h0;
  logic [3:0] init_cbe_n = 4'hf, cbe_n_in = 4'hf, master_request_n = 4'hf;
  logic [6:0] ev = 7'h0;
  logic stop_n_in, ecc_single_err, ecc_multi_err, gfx_target_abort;
  logic gfx_parity_err, gtt_invalid_hit, gfx_out_of_range;
  logic par_out, par_oe, trdy_n_out, trdy_oe, stop_n_out, stop_oe, exclusive_lock_n_out;
  logic exclusive_lock_oe, serr_n_out, serr_oe, init_trdy_seen, init_stop_seen;
  logic init_target_abort, tgt_selected, pci_lock_ignored, posted_writes_enable;
  logic south_bridge_hold_ack_n, south_bridge_hold_req_n, posted_writes_empty;
  logic [3:0] tgt_cmd, master_grant_n;
  logic [31:0] tgt_addr;
  int failures = 0;
  int n_compared = 0;

  // Error sources are pulsed from one vector; bit 6 is a target abort seen as initiator.
  always_comb begin
    {stop_n_in, ecc_single_err, ecc_multi_err, gfx_target_abort} = {~ev[6], ev[5:3]};
    {gfx_parity_err, gtt_invalid_hit, gfx_out_of_range} = ev[2:0];
  end

  hbpci_ctrl hbpci_ctrl_i (
    .clk_sys, .rst, .system_error_enable, .ecc_mode, .ecc_report_single,
    .ecc_report_multi, .ecc_single_err, .ecc_multi_err, .ecc_init_done,
    .report_pci_parity, .report_gfx_parity, .report_gtt_invalid, .report_gfx_range,
    .gfx_parity_err, .gtt_invalid_hit, .gfx_out_of_range, .gfx_target_abort,
    .init_active, .init_is_write, .init_addr_phase, .init_data_phase, .init_ad,
    .init_cbe_n, .cpu_lock_req, .tgt_ready, .tgt_disconnect, .tgt_retry, .tgt_abort,
    .tgt_read_data, .frame_n_in, .irdy_n_in, .trdy_n_in, .stop_n_in, .devsel_n_in,
    .ad_in, .cbe_n_in, .par_in, .exclusive_lock_n_in, .par_out, .par_oe, .trdy_n_out,
    .trdy_oe, .stop_n_out, .stop_oe, .exclusive_lock_n_out, .exclusive_lock_oe,
    .serr_n_out, .serr_oe, .init_trdy_seen, .init_stop_seen, .init_target_abort,
    .tgt_selected, .tgt_cmd, .tgt_addr, .pci_lock_ignored, .posted_writes_empty,
    .posted_writes_enable, .south_bridge_hold_req_n, .south_bridge_hold_ack_n,
    .master_request_n, .master_grant_n
  );
  hbpci_far_side hbpci_far_side_i (
    .clk_sys, .rst, .hold_start, .south_bridge_hold_ack_n, .south_bridge_hold_req_n,
    .posted_writes_empty
  );

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic t_init_parity();
    logic [31:0] d;
    init_active = 1'b1;
    cpu_lock_req = 1'b1;
    trdy_n_in = 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = 32'h8000_0003 << i;
      init_is_write = (i < 2);
      init_addr_phase = ~i[0];
      init_data_phase = i[0];
      init_ad = d;
      init_cbe_n = 4'h6 ^ i[3:0];
      step();
      chk("init_trdy_seen", 1, init_trdy_seen);
      init_addr_phase = 1'b0;
      init_data_phase = 1'b0;
      chk("par_oe", (i != 3), par_oe);
      if (i != 3) chk("par_out", ^{d, 4'h6 ^ i[3:0]}, par_out);
      step();
    end
    chk("lock_oe", 1, exclusive_lock_oe);
    chk("lock_n", 0, exclusive_lock_n_out);
    init_active = 1'b0;
    cpu_lock_req = 1'b0;
    trdy_n_in = 1'b1;
  endtask : t_init_parity

  task automatic t_target_read();
    frame_n_in = 1'b0;
    ad_in = 32'h1234_5678;
    cbe_n_in = 4'h6;
    step();
    chk("tgt_selected", 1, tgt_selected);
    chk("tgt_cmd", 4'h6, tgt_cmd);
    chk("tgt_addr", 32'h1234_5678, tgt_addr);
    chk("lock_released", 0, exclusive_lock_oe);
    irdy_n_in = 1'b0;
    cbe_n_in = 4'h0;
    tgt_read_data = 32'h0f0f_0e0f;
    #1;
    chk("trdy_oe", 1, trdy_oe);
    chk("trdy_wait", 1, trdy_n_out);
    chk("stop_oe", 1, stop_oe);
    chk("stop_idle", 1, stop_n_out);
    step();
    frame_n_in = 1'b1;
    tgt_ready = 1'b1;
    #1;
    chk("trdy_ready", 0, trdy_n_out);
    chk("par_oe_tgt", 1, par_oe);
    chk("par_tgt", ^{32'h0f0f_0e0f, 4'h0}, par_out);
    step();
    irdy_n_in = 1'b1;
    tgt_ready = 1'b0;
    chk("tgt_released", 0, tgt_selected);
    chk("trdy_released", 0, trdy_oe);
  endtask : t_target_read

  task automatic t_target_stop();
    system_error_enable = 1'b1;
    frame_n_in = 1'b0;
    ad_in = 32'h0000_0001;
    cbe_n_in = 4'h7;
    step();
    irdy_n_in = 1'b0;
    cbe_n_in = 4'h0;
    par_in = 1'b1;
    tgt_retry = 1'b1;
    exclusive_lock_n_in = 1'b0;
    #1;
    chk("stop_retry", 0, stop_n_out);
    chk("trdy_retry", 1, trdy_n_out);
    chk("lock_ignored", 1, pci_lock_ignored);
    chk("lock_not_driven", 0, exclusive_lock_oe);
    step();
    frame_n_in = 1'b1;
    par_in = 1'b0;
    chk("serr_addr_parity", 0, serr_n_out);
    step();
    chk("tgt_retry_end", 0, tgt_selected);
    chk("serr_parity_one", 1, serr_n_out);
    irdy_n_in = 1'b1;
    tgt_retry = 1'b0;
    exclusive_lock_n_in = 1'b1;
    system_error_enable = 1'b0;
  endtask : t_target_stop

  task automatic t_serr();
    init_active = 1'b1;
    for (int en = 0; en < 2; en++) begin
      system_error_enable = en[0];
      for (int i = 0; i < 7; i++) begin
        ev = 7'h1 << i;
        step();
        if (i == 6) chk("init_stop_seen", 1, init_stop_seen);
        if (i == 6) chk("init_target_abort", 1, init_target_abort);
        ev = 7'h0;
        chk("serr_low", !en[0], serr_n_out);
        chk("serr_oe", en[0], serr_oe);
        step();
        chk("serr_one_clock", 1, serr_n_out);
      end
    end
    ecc_init_done = 1'b0;
    ev = 7'h20;
    step();
    ev = 7'h0;
    chk("serr_ecc_init", 1, serr_n_out);
    step();
    system_error_enable = 1'b0;
    ecc_init_done = 1'b1;
    init_active = 1'b0;
  endtask : t_serr

  task automatic t_arbiter();
    logic [3:0] g;
    logic [3:0] e;
    master_request_n = 4'ha;
    step();
    step();
    g = ~master_grant_n;
    chk("one_grant", 1, $onehot(g) && ((g & 4'ha) == 4'h0));
    master_request_n = 4'ha | g;
    e = ~(4'h5 & ~g);
    step();
    step();
    step();
    chk("grant_moves", e, master_grant_n);
    master_request_n = 4'hf;
    step();
    step();
    chk("grant_none", 4'hf, master_grant_n);
  endtask : t_arbiter

  task automatic t_hold();
    int n;
    n = 0;
    hold_start = 1'b1;
    master_request_n = 4'hd;
    step();
    hold_start = 1'b0;
    while (south_bridge_hold_ack_n !== 1'b0 && n < 50) begin
      step();
      n++;
    end
    chk("ack_given", 0, south_bridge_hold_ack_n);
    chk("flush_before_ack", 1, posted_writes_empty);
    chk("writes_off_at_ack", 0, posted_writes_enable);
    chk("no_grant_at_ack", 4'hf, master_grant_n);
    step();
    step();
    chk("no_grant_in_hold", 4'hf, master_grant_n);
    while (south_bridge_hold_req_n !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk("ack_kept", 0, south_bridge_hold_ack_n);
    step();
    chk("ack_released", 1, south_bridge_hold_ack_n);
    step();
    chk("writes_on", 1, posted_writes_enable);
    master_request_n = 4'hf;
  endtask : t_hold

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("grant_reset", 4'hf, master_grant_n);
    chk("hold_ack_reset", 1, south_bridge_hold_ack_n);
    step();
    t_init_parity();
    t_target_read();
    t_target_stop();
    t_serr();
    t_arbiter();
    t_hold();
    final_report();
  end

  initial begin
    #(5 * 4000);
    failures++;
    final_report();
  end
endmodule : hbpci_ctrl_tb_top
`default_nettype wire
